// ### pkg/ppit_pkg.sv
// ppit_pkg: register map, control bit layout, reset values and state type
// for the two-port, two-timer peripheral; used by the design, the bench uses literal values.
package ppit_pkg;
	localparam logic [3:0] OFF_PORT_A_DATA = 4'h0;
	localparam logic [3:0] OFF_PORT_B_DATA = 4'h1;
	localparam logic [3:0] OFF_PORT_A_DIR  = 4'h2;
	localparam logic [3:0] OFF_PORT_B_DIR  = 4'h3;
	localparam logic [3:0] OFF_TA_LOW      = 4'h4;
	localparam logic [3:0] OFF_TA_HIGH     = 4'h5;
	localparam logic [3:0] OFF_TB_LOW      = 4'h6;
	localparam logic [3:0] OFF_TB_HIGH     = 4'h7;
	localparam logic [3:0] OFF_TA_CTRL     = 4'he;
	localparam logic [3:0] OFF_TB_CTRL     = 4'hf;
	// control register bits
	localparam int CTL_RUN     = 0;
	localparam int CTL_PB_EN   = 1;
	localparam int CTL_TOGGLE  = 2;
	localparam int CTL_ONESHOT = 3;
	localparam int CTL_LOAD    = 4;
	localparam int CTL_SRC_LO  = 5;
	localparam int CTL_SRC_HI  = 6;
	// count source codes (timer a uses only bit CTL_SRC_LO)
	localparam logic [1:0] SRC_CLK    = 2'h0;
	localparam logic [1:0] SRC_CNT    = 2'h1;
	localparam logic [1:0] SRC_TA     = 2'h2;
	localparam logic [1:0] SRC_TA_CNT = 2'h3;
	localparam logic [7:0]  RST_BYTE  = 8'h00;
	localparam logic [15:0] RST_LATCH = 16'hffff;
	localparam int PB_TA_BIT = 6;
	localparam int PB_TB_BIT = 7;

	typedef struct packed {
		logic [15:0] latch;
		logic [15:0] count;
		logic [7:0]  ctrl;
		logic        tgl;
		logic        pulse;
	} ppit_timer_t;

	typedef struct packed {
		logic [7:0]  pa_data;
		logic [7:0]  pb_data;
		logic [7:0]  pa_dir;
		logic [7:0]  pb_dir;
		ppit_timer_t ta;
		ppit_timer_t tb;
		logic [7:0]  rdata;
		logic        strobe_n;
		logic [1:0]  hs_sync;
		logic        hs_prev;
		logic        hs_flag;
		logic        cnt_sync1;
		logic        cnt_sync2;
		logic        cnt_prev;
		logic        ta_uf;
		logic        tb_uf;
		logic        ph_prev;
	} ppit_state_t;
endpackage

// ### src/ppit_top.sv
// ppit_top: two 8-bit parallel ports and two 16-bit interval timers
// behind a 4-bit register select. bus strobes are sampled on mclk_in;
// a request is acted on at the rising edge of the qualifying phase.
// Functional notes
// R1: each port has data and direction registers; direction one means output.
// R2: port data reads return actual pin levels, inputs and outputs alike.
// R3: port b strobe goes low one clock after each port b data access.
// R4: falling edge on handshake input sets the handshake flag only.
// R5: processor accesses port a before port b for 16-bit transfers.
// R6: timers have read-only counter, write-only reload latch.
// R7: run bit starts or halts a timer at any time.
// R8: port-output enable drives timer a on port b bit 6, timer b on bit 7.
// R9: select bit picks toggle or one-cycle pulse output per underflow.
// R10: toggle output set high on start, low on reset.
// R11: one-shot: count to zero, flag, reload, stop.
// R12: continuous: count to zero, flag, reload, repeat.
// R13: force-load strobe copies latch to counter immediately.
// R14: timer a counts clock phases or count-pin pulses.
// R15: timer b counts clock, count pin, timer a underflow, or gated underflow.
// R16: reload on underflow, force load, high-byte write while halted.
// R17: high-byte write while running changes only the latch.
// R18: select 0..3 are port a data, port b data, directions a, b.
// R19: select 4..7 are timer a low, high, timer b low, high.
// R20: control registers at select e and f.
// R21: reset: pins input, registers zero, latches all ones.
// R22: run bit clears itself on one-shot underflow.
// R23: access only while chip select low and phase high; rw high reads.
// R24: decrement once per count event; underflow pulses go out.
// R25: handshake input synchronised before falling-edge detection.
`timescale 1ns/1ps
module ppit_top (
	// clock and reset
	input  wire logic       mclk_in,
	input  wire logic       rst_in,
	// processor bus
	input  wire logic       phase_in,
	input  wire logic       chip_select_n_in,
	input  wire logic       read_write_in,
	input  wire logic [3:0] register_select_in,
	input  wire logic [7:0] data_in,
	output logic      [7:0] data_out,
	output logic            data_oe_n_out,
	// ports
	input  wire logic [7:0] port_a_pins_in,
	output logic      [7:0] port_a_pins_out,
	output logic      [7:0] port_a_pins_oe_n_out,
	input  wire logic [7:0] port_b_pins_in,
	output logic      [7:0] port_b_pins_out,
	output logic      [7:0] port_b_pins_oe_n_out,
	output logic            port_b_strobe_n_out,
	// handshake, count pin, underflow events
	input  wire logic       handshake_n_in,
	input  wire logic       count_input_pin_in,
	output logic            handshake_flag_out,
	output logic            timer_a_underflow_out,
	output logic            timer_b_underflow_out
);
	ppit_pkg::ppit_state_t cur_ff;
	ppit_pkg::ppit_state_t nxt_st;
	logic [7:0] nxt_pb_out;
	logic [7:0] nxt_pb_oe_n;
	logic [7:0] pb_out_ff;
	logic [7:0] pb_oe_n_ff;
	logic [7:0] pa_oe_n_ff;
	logic       oe_n_ff;

	// one timer step; evt already chosen by caller
	function automatic ppit_pkg::ppit_timer_t tmr_step(
		input ppit_pkg::ppit_timer_t t,
		input logic                  evt,
		output logic                 uf
	);
		ppit_pkg::ppit_timer_t n;
		n = t;
		uf = 1'b0;
		n.pulse = 1'b0;
		if (t.ctrl[ppit_pkg::CTL_RUN] && evt) // [R7] [R24]
		begin
			if (t.count == 16'h0000)
			begin
				uf = 1'b1;
				n.count = t.latch; // [R11] [R12] [R16]
				n.tgl = ~t.tgl; // [R9]
				n.pulse = 1'b1; // [R9]
				if (t.ctrl[ppit_pkg::CTL_ONESHOT])
					n.ctrl[ppit_pkg::CTL_RUN] = 1'b0; // [R11] [R22]
			end
			else
				n.count = t.count - 16'h0001; // [R24]
		end
		return n;
	endfunction

	// bus write into one timer; runs after the count step so writes win
	function automatic ppit_pkg::ppit_timer_t tmr_write(
		input ppit_pkg::ppit_timer_t t,
		input logic                  wr_lo,
		input logic                  wr_hi,
		input logic                  wr_ctl,
		input logic [7:0]            d
	);
		ppit_pkg::ppit_timer_t n;
		n = t;
		n.ctrl[ppit_pkg::CTL_LOAD] = 1'b0;
		if (wr_lo)
			n.latch[7:0] = d; // [R6]
		if (wr_hi)
		begin
			n.latch[15:8] = d; // [R6]
			if (!t.ctrl[ppit_pkg::CTL_RUN])
				n.count = {d, t.latch[7:0]}; // [R16]
			// running: counter untouched [R17]
		end
		if (wr_ctl)
		begin
			n.ctrl = d;
			n.ctrl[ppit_pkg::CTL_LOAD] = 1'b0; // strobe, never stored
			if (d[ppit_pkg::CTL_LOAD])
				n.count = t.latch; // [R13]
			if (d[ppit_pkg::CTL_RUN] && !t.ctrl[ppit_pkg::CTL_RUN])
				n.tgl = 1'b1; // [R10]
		end
		return n;
	endfunction

	logic       access;
	logic       rd;
	logic       wr;
	logic       cnt_rise;
	logic       ta_evt;
	logic       tb_evt;
	logic       ta_uf;
	logic       tb_uf;
	logic [1:0] tb_src;
	logic [7:0] pa_pins;
	logic [7:0] pb_pins;

	always_comb
	begin
		nxt_st = cur_ff;
		ta_uf = 1'b0;
		tb_uf = 1'b0;
		// one access per phase-high period, taken on its rising edge [R23]
		access = phase_in && !cur_ff.ph_prev && !chip_select_n_in;
		rd = access && read_write_in; // [R23]
		wr = access && !read_write_in; // [R23]
		nxt_st.ph_prev = phase_in;
		pa_pins = port_a_pins_in;
		pb_pins = port_b_pins_in;

		// count pin sampled twice; edge taken from the second stage only
		nxt_st.cnt_sync1 = count_input_pin_in;
		nxt_st.cnt_sync2 = cur_ff.cnt_sync1;
		nxt_st.cnt_prev = cur_ff.cnt_sync2;
		cnt_rise = cur_ff.cnt_sync2 && !cur_ff.cnt_prev;

		// timer a: clock phase or count pin [R14]
		ta_evt = cur_ff.ta.ctrl[ppit_pkg::CTL_SRC_LO] ? cnt_rise :
			(phase_in && !cur_ff.ph_prev);
		nxt_st.ta = tmr_step(cur_ff.ta, ta_evt, ta_uf);
		// timer b: four sources [R15]
		tb_src = cur_ff.tb.ctrl[ppit_pkg::CTL_SRC_HI:ppit_pkg::CTL_SRC_LO];
		unique case (tb_src)
			ppit_pkg::SRC_CLK:    tb_evt = phase_in && !cur_ff.ph_prev;
			ppit_pkg::SRC_CNT:    tb_evt = cnt_rise;
			ppit_pkg::SRC_TA:     tb_evt = ta_uf;
			ppit_pkg::SRC_TA_CNT: tb_evt = ta_uf && cur_ff.cnt_sync2;
		endcase
		nxt_st.tb = tmr_step(cur_ff.tb, tb_evt, tb_uf);
		nxt_st.ta_uf = ta_uf; // [R24]
		nxt_st.tb_uf = tb_uf; // [R24]

		nxt_st.ta = tmr_write(nxt_st.ta, wr && register_select_in == ppit_pkg::OFF_TA_LOW,
			wr && register_select_in == ppit_pkg::OFF_TA_HIGH,
			wr && register_select_in == ppit_pkg::OFF_TA_CTRL, data_in); // [R19] [R20]
		nxt_st.tb = tmr_write(nxt_st.tb, wr && register_select_in == ppit_pkg::OFF_TB_LOW,
			wr && register_select_in == ppit_pkg::OFF_TB_HIGH,
			wr && register_select_in == ppit_pkg::OFF_TB_CTRL, data_in); // [R19] [R20]

		if (wr)
		begin
			unique case (register_select_in) // [R18]
				ppit_pkg::OFF_PORT_A_DATA: nxt_st.pa_data = data_in; // [R1]
				ppit_pkg::OFF_PORT_B_DATA: nxt_st.pb_data = data_in; // [R1]
				ppit_pkg::OFF_PORT_A_DIR:  nxt_st.pa_dir = data_in; // [R1]
				ppit_pkg::OFF_PORT_B_DIR:  nxt_st.pb_dir = data_in; // [R1]
				default: ;
			endcase
		end
		if (rd)
		begin
			unique case (register_select_in)
				ppit_pkg::OFF_PORT_A_DATA: nxt_st.rdata = pa_pins; // [R2]
				ppit_pkg::OFF_PORT_B_DATA: nxt_st.rdata = pb_pins; // [R2]
				ppit_pkg::OFF_PORT_A_DIR:  nxt_st.rdata = cur_ff.pa_dir;
				ppit_pkg::OFF_PORT_B_DIR:  nxt_st.rdata = cur_ff.pb_dir;
				ppit_pkg::OFF_TA_LOW:      nxt_st.rdata = cur_ff.ta.count[7:0]; // [R6]
				ppit_pkg::OFF_TA_HIGH:     nxt_st.rdata = cur_ff.ta.count[15:8]; // [R6]
				ppit_pkg::OFF_TB_LOW:      nxt_st.rdata = cur_ff.tb.count[7:0]; // [R6]
				ppit_pkg::OFF_TB_HIGH:     nxt_st.rdata = cur_ff.tb.count[15:8]; // [R6]
				ppit_pkg::OFF_TA_CTRL:     nxt_st.rdata = cur_ff.ta.ctrl;
				ppit_pkg::OFF_TB_CTRL:     nxt_st.rdata = cur_ff.tb.ctrl;
				default:                   nxt_st.rdata = ppit_pkg::RST_BYTE;
			endcase
		end

		// strobe low for exactly one clock after a port b data access [R3] [R5]
		nxt_st.strobe_n = !(access && register_select_in == ppit_pkg::OFF_PORT_B_DATA);

		// handshake: two-stage sync, falling edge sets sticky flag [R25] [R4]
		nxt_st.hs_sync = {cur_ff.hs_sync[0], handshake_n_in};
		nxt_st.hs_prev = cur_ff.hs_sync[1];
		if (cur_ff.hs_prev && !cur_ff.hs_sync[1])
			nxt_st.hs_flag = 1'b1; // [R4]

		// pin drive; timer output overrides direction bit [R8]
		nxt_pb_out = nxt_st.pb_data;
		nxt_pb_oe_n = ~nxt_st.pb_dir; // [R1]
		if (nxt_st.ta.ctrl[ppit_pkg::CTL_PB_EN])
		begin
			nxt_pb_out[ppit_pkg::PB_TA_BIT] = nxt_st.ta.ctrl[ppit_pkg::CTL_TOGGLE] ?
				nxt_st.ta.tgl : nxt_st.ta.pulse; // [R8] [R9]
			nxt_pb_oe_n[ppit_pkg::PB_TA_BIT] = 1'b0; // [R8]
		end
		if (nxt_st.tb.ctrl[ppit_pkg::CTL_PB_EN])
		begin
			nxt_pb_out[ppit_pkg::PB_TB_BIT] = nxt_st.tb.ctrl[ppit_pkg::CTL_TOGGLE] ?
				nxt_st.tb.tgl : nxt_st.tb.pulse; // [R8] [R9]
			nxt_pb_oe_n[ppit_pkg::PB_TB_BIT] = 1'b0; // [R8]
		end
	end

	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			cur_ff <= '0; // [R21]
			cur_ff.ta.latch <= ppit_pkg::RST_LATCH; // [R21]
			cur_ff.tb.latch <= ppit_pkg::RST_LATCH; // [R21]
			cur_ff.strobe_n <= 1'b1;
			cur_ff.hs_sync <= 2'b11;
			cur_ff.hs_prev <= 1'b1;
			pb_out_ff <= 8'h00;
			pb_oe_n_ff <= 8'hff; // [R21]
			pa_oe_n_ff <= 8'hff; // [R21]
			oe_n_ff <= 1'b1;
		end
		else
		begin
			cur_ff <= nxt_st;
			pb_out_ff <= nxt_pb_out;
			pb_oe_n_ff <= nxt_pb_oe_n;
			pa_oe_n_ff <= ~nxt_st.pa_dir;
			// bus driven for the phase-high read, one clock behind phase
			oe_n_ff <= !(phase_in && !chip_select_n_in && read_write_in);
		end
	end

	assign data_out              = cur_ff.rdata;
	assign data_oe_n_out         = oe_n_ff;
	assign port_a_pins_out       = cur_ff.pa_data;
	assign port_a_pins_oe_n_out  = pa_oe_n_ff;
	assign port_b_pins_out       = pb_out_ff;
	assign port_b_pins_oe_n_out  = pb_oe_n_ff;
	assign port_b_strobe_n_out   = cur_ff.strobe_n;
	assign handshake_flag_out    = cur_ff.hs_flag;
	assign timer_a_underflow_out = cur_ff.ta_uf;
	assign timer_b_underflow_out = cur_ff.tb_uf;
endmodule

// ### test/ppit_top_props.sv
// ppit_top_props: bus, port, strobe and event checks on the top ports
// assumes one mclk domain and a reset held over at least one edge
`timescale 1ns/1ps
module ppit_top_props (
	input wire logic       mclk_in,
	input wire logic       rst_in,
	input wire logic       phase_in,
	input wire logic       chip_select_n_in,
	input wire logic       read_write_in,
	input wire logic [3:0] register_select_in,
	input wire logic [7:0] data_in,
	input wire logic       data_oe_n_out,
	input wire logic [7:0] port_a_pins_out,
	input wire logic [7:0] port_a_pins_oe_n_out,
	input wire logic [7:0] port_b_pins_oe_n_out,
	input wire logic       port_b_strobe_n_out,
	input wire logic       handshake_n_in,
	input wire logic       handshake_flag_out,
	input wire logic       timer_a_underflow_out
);
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (rst_in);
	// taken edge was one cycle back: phase newly high, selected
	sequence s_acc(logic [3:0] rs);
		$past(phase_in && !chip_select_n_in && register_select_in == rs) && !$past(phase_in, 2);
	endsequence
	sequence s_wr(logic [3:0] rs);
		s_acc(rs) ##0 !$past(read_write_in);
	endsequence
	a_strobe_one_cyc: assert property ($fell(port_b_strobe_n_out) |=> port_b_strobe_n_out)
		else $error("strobe low longer than one cycle");
	a_strobe_cause: assert property ($fell(port_b_strobe_n_out) |-> s_acc(4'h1))
		else $error("strobe without port b access");
	a_strobe_follows: assert property (s_acc(4'h1) |-> !port_b_strobe_n_out)
		else $error("port b access without strobe");
	a_reset_idle: assert property ($fell(rst_in) |-> &port_a_pins_oe_n_out
		&& &port_b_pins_oe_n_out && data_oe_n_out) else $error("pins driven after reset");
	a_dir_value: assert property (s_wr(4'h2) |-> port_a_pins_oe_n_out == ~$past(data_in))
		else $error("port a direction not written");
	a_data_value: assert property (s_wr(4'h0) |-> port_a_pins_out == $past(data_in))
		else $error("port a data not written");
	a_read_drive: assert property (!data_oe_n_out |-> $past(phase_in && !chip_select_n_in
		&& read_write_in)) else $error("bus driven outside a read");
	a_uf_pulse: assert property (timer_a_underflow_out |=> !timer_a_underflow_out)
		else $error("underflow pulse too long");
	a_hs_flag: assert property ($rose(handshake_flag_out) |-> !$past(handshake_n_in, 3))
		else $error("flag set without falling edge");
endmodule
bind ppit_top ppit_top_props i_props (.mclk_in(mclk_in), .rst_in(rst_in), .phase_in(phase_in),
	.chip_select_n_in(chip_select_n_in), .read_write_in(read_write_in),
	.register_select_in(register_select_in), .data_in(data_in), .data_oe_n_out(data_oe_n_out),
	.port_a_pins_out(port_a_pins_out), .port_a_pins_oe_n_out(port_a_pins_oe_n_out),
	.port_b_pins_oe_n_out(port_b_pins_oe_n_out), .port_b_strobe_n_out(port_b_strobe_n_out),
	.handshake_n_in(handshake_n_in), .handshake_flag_out(handshake_flag_out),
	.timer_a_underflow_out(timer_a_underflow_out));

// ### test/ppit_cpu_model.sv
// ppit_cpu_model: processor side of the register bus
// assumes the device takes an access at the edge that sees phase rise
`timescale 1ns/1ps
module ppit_cpu_model (
	input  wire logic       mclk_in,
	input  wire logic [7:0] rdata_in,
	output logic            phase_out,
	output logic            cs_n_out,
	output logic            rw_out,
	output logic      [3:0] rs_out,
	output logic      [7:0] wdata_out
);
	initial
	begin
		phase_out = 1'b0;
		cs_n_out = 1'b1;
		rw_out = 1'b1;
		rs_out = 4'h0;
		wdata_out = 8'h00;
	end
	// held from phase rise past the taken edge; rw high reads
	task automatic access(input logic rw, input logic [3:0] rs, input logic [7:0] wd,
		output logic [7:0] rd);
		@(posedge mclk_in);
		#1;
		phase_out = 1'b1;
		cs_n_out = 1'b0;
		rw_out = rw;
		rs_out = rs;
		wdata_out = rw ? ~wdata_out : wd;
		repeat (2) @(posedge mclk_in);
		#1;
		rd = rdata_in;
		phase_out = 1'b0;
		cs_n_out = 1'b1;
		// released data lines must not look like the last value
		wdata_out = ~wdata_out;
	endtask
	// idle phase cycles, each one count event for clock-sourced timers
	task automatic tick(input int n);
		repeat (n)
		begin
			@(posedge mclk_in);
			#1;
			phase_out = 1'b1;
			@(posedge mclk_in);
			#1;
			phase_out = 1'b0;
		end
	endtask
endmodule

// ### test/ppit_top_tb.sv
// ppit_top_tb: ports, strobe, timers and handshake through the register bus
// assumes pull-ups on every port pin and the cpu model as bus master
`timescale 1ns/1ps
module ppit_top_tb;
	logic       mclk_in, rst_in, hs_n, phase, cs_n, rw, oe_n, strobe_n, flag, uf_a, uf_b;
	logic       count_pin;
	logic [3:0] rs;
	logic [7:0] wd, rdata, pa_out, pa_oe_n, pb_out, pb_oe_n, rd;
	int         num_errors = 0, n_compared = 0, n_uf_a = 0, n_uf_b = 0, n_pulse_b = 0;
	ppit_top i_dut (.mclk_in(mclk_in), .rst_in(rst_in), .phase_in(phase),
		.chip_select_n_in(cs_n), .read_write_in(rw), .register_select_in(rs), .data_in(wd),
		.data_out(rdata), .data_oe_n_out(oe_n), .port_a_pins_in(pa_out | pa_oe_n),
		.port_a_pins_out(pa_out), .port_a_pins_oe_n_out(pa_oe_n),
		.port_b_pins_in(pb_out | pb_oe_n), .port_b_pins_out(pb_out),
		.port_b_pins_oe_n_out(pb_oe_n), .port_b_strobe_n_out(strobe_n),
		.handshake_n_in(hs_n), .count_input_pin_in(count_pin), .handshake_flag_out(flag),
		.timer_a_underflow_out(uf_a), .timer_b_underflow_out(uf_b));
	ppit_cpu_model i_cpu (.mclk_in(mclk_in), .rdata_in(rdata), .phase_out(phase),
		.cs_n_out(cs_n), .rw_out(rw), .rs_out(rs), .wdata_out(wd));
	initial
	begin
		mclk_in = 1'b0;
		forever #12.5 mclk_in = ~mclk_in;
	end
	// counted off the edge so flop updates have landed
	always @(negedge mclk_in)
	begin
		n_uf_a += (uf_a === 1'b1);
		n_uf_b += (uf_b === 1'b1);
		n_pulse_b += (pb_out[7] === 1'b1);
	end
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_compared++;
		if (got !== exp)
		begin
			$display("wrong value %s: expected %h seen %h", what, exp, got);
			num_errors++;
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		i_cpu.access(1'b0, a, d, rd);
	endtask
	// one more edge so the negedge counters have seen the last pulse
	task automatic settle;
		@(posedge mclk_in);
		#1;
	endtask
	// each rise reaches the timers three edges later, hence the tail wait
	task automatic pulse_cnt(input int n);
		repeat (n)
		begin
			@(posedge mclk_in);
			#1;
			count_pin = 1'b0;
			repeat (2) @(posedge mclk_in);
			#1;
			count_pin = 1'b1;
			repeat (2) @(posedge mclk_in);
		end
		repeat (2) @(posedge mclk_in);
		#1;
	endtask
	task automatic rdc(input string what, input logic [3:0] a, input logic [7:0] exp);
		i_cpu.access(1'b1, a, 8'h00, rd);
		chk(what, exp, rd);
	endtask
	task automatic t_reset;
		chk("pa oe_n", 8'hff, pa_oe_n);
		rdc("pa pins", 4'h0, 8'hff);
		rdc("pb dir", 4'h3, 8'h00);
		rdc("ta ctl", 4'he, 8'h00);
		rdc("tb ctl", 4'hf, 8'h00);
		wr(4'h5, 8'h00);
		rdc("ta latch lo", 4'h4, 8'hff);
		$display("test reset done");
	endtask
	task automatic t_ports;
		wr(4'h2, 8'h0f);
		wr(4'h0, 8'ha5);
		rdc("pa pins", 4'h0, 8'hf5);
		wr(4'h3, 8'h0f);
		wr(4'h1, 8'h3c);
		rdc("pb pins", 4'h1, 8'hfc);
		rdc("pa dir", 4'h2, 8'h0f);
		rdc("unmapped", 4'h8, 8'h00);
		$display("test ports done");
	endtask
	task automatic t_oneshot;
		wr(4'h4, 8'h03);
		wr(4'h5, 8'h00);
		rdc("ta count lo", 4'h4, 8'h03);
		wr(4'he, 8'h0f);
		chk("port b bit 6 start", 8'h01, {7'h0, pb_out[6]});
		chk("port b bit 6 oe_n", 8'h00, {7'h0, pb_oe_n[6]});
		n_uf_a = 0;
		i_cpu.tick(4);
		settle();
		chk("ta uf", 8'h01, n_uf_a[7:0]);
		chk("port b bit 6 toggled", 8'h00, {7'h0, pb_out[6]});
		i_cpu.tick(3);
		chk("ta uf stop", 8'h01, n_uf_a[7:0]);
		rdc("ta ctl", 4'he, 8'h0e);
		rdc("ta reload", 4'h4, 8'h03);
		wr(4'h4, 8'h05);
		wr(4'he, 8'h1e);
		rdc("ta force", 4'h4, 8'h05);
		$display("test one-shot done");
	endtask
	task automatic t_contin;
		wr(4'h6, 8'h01);
		wr(4'h7, 8'h00);
		wr(4'hf, 8'h03);
		n_uf_b = 0;
		n_pulse_b = 0;
		i_cpu.tick(8);
		settle();
		chk("tb uf", 8'h04, n_uf_b[7:0]);
		chk("port b bit 7 pulses", 8'h04, n_pulse_b[7:0]);
		chk("port b bit 7 pulse idle", 8'h00, {7'h0, pb_out[7]});
		wr(4'h7, 8'h00);
		rdc("tb count lo", 4'h6, 8'h00);
		wr(4'hf, 8'h00);
		$display("test continuous done");
	endtask
	task automatic t_count;
		wr(4'h4, 8'h02);
		wr(4'h5, 8'h00);
		wr(4'h6, 8'h01);
		wr(4'h7, 8'h00);
		wr(4'hf, 8'h41);
		wr(4'he, 8'h21);
		n_uf_a = 0;
		n_uf_b = 0;
		pulse_cnt(6);
		chk("ta uf pin", 8'h02, n_uf_a[7:0]);
		chk("tb uf from ta", 8'h01, n_uf_b[7:0]);
		count_pin = 1'b0;
		wr(4'hf, 8'h71);
		wr(4'he, 8'h11);
		n_uf_a = 0;
		n_uf_b = 0;
		i_cpu.tick(3);
		settle();
		chk("ta uf clk", 8'h01, n_uf_a[7:0]);
		chk("tb gated low", 8'h00, n_uf_b[7:0]);
		count_pin = 1'b1;
		i_cpu.tick(6);
		settle();
		chk("tb gated high", 8'h01, n_uf_b[7:0]);
		wr(4'hf, 8'h31);
		n_uf_b = 0;
		pulse_cnt(2);
		chk("tb uf pin", 8'h01, n_uf_b[7:0]);
		wr(4'he, 8'h00);
		wr(4'hf, 8'h00);
		$display("test count sources done");
	endtask
	task automatic t_hs;
		chk("flag idle", 8'h00, {7'h0, flag});
		@(posedge mclk_in);
		#1;
		hs_n = 1'b0;
		repeat (5) @(posedge mclk_in);
		#1;
		chk("flag set", 8'h01, {7'h0, flag});
		$display("test handshake done");
	endtask
	task automatic finish_test;
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial
	begin
		#50000;
		num_errors++;
		finish_test();
	end
	initial
	begin
		rst_in = 1'b1;
		hs_n = 1'b1;
		count_pin = 1'b0;
		repeat (2) @(posedge mclk_in);
		#1;
		rst_in = 1'b0;
		t_reset();
		t_ports();
		t_oneshot();
		t_contin();
		t_count();
		t_hs();
		finish_test();
	end
endmodule
